//--- margin_pkg.sv
// constants for the field margin level command slice
package margin_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_STATUS   = 5'h00;
   localparam logic [4:0] OFF_INDEX    = 5'h04;
   localparam logic [4:0] OFF_PARAM    = 5'h08;
   localparam logic [4:0] OFF_MODE     = 5'h0C;
   localparam logic [4:0] OFF_LEVELS   = 5'h10;
   localparam logic [4:0] OFF_IRQ_STAT = 5'h14;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
   // nvm_status_register bit positions
   localparam int BIT_COMMAND_COMPLETE_FLAG   = 7;
   localparam int BIT_ACCESS_ERROR_FLAG = 5;
   localparam int BIT_PROTECTION_VIOLATION_FLAG = 4;
   // irq status bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;
   // levels register field positions
   localparam int LVL_PFLASH_LSB = 0;
   localparam int LVL_EEPROM_LSB = 4;
   localparam int LVL_BUSY       = 8;
   // command code, block selection codes and last parameter index
   localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0E;
   localparam logic [1:0] SEL_PFLASH       = 2'h0;
   localparam logic [1:0] SEL_EEPROM       = 2'h1;
   localparam logic [2:0] IDX_LAST_MARGIN  = 3'h1;
   // margin level codes
   localparam logic [15:0] LVL_NORMAL = 16'h0000;
   localparam logic [15:0] LVL_USER1  = 16'h0001;
   localparam logic [15:0] LVL_USER0  = 16'h0002;
   localparam logic [15:0] LVL_FIELD1 = 16'h0003;
   localparam logic [15:0] LVL_FIELD0 = 16'h0004;
   // reset values
   localparam logic [2:0] RST_LEVEL = 3'h0;
   localparam logic [2:0] RST_INDEX = 3'h0;
   localparam logic       RST_COMMAND_COMPLETE_FLAG  = 1'b1;
   localparam logic [1:0] RST_MASK  = 2'h0;
   // depth of the command parameter array
   localparam int PARAM_WORDS = 6;
endpackage

//--- margin_check.sv
// launch checks and level decode for the field margin level command
`timescale 1ns/1ps
module margin_check (
   input  wire logic [15:0] param_cmd,
   input  wire logic [15:0] param_level,
   input  wire logic [2:0]  command_param_index,
   input  wire logic        cmd_allowed,
   output logic             fault,
   output logic             target_pflash,
   output logic [2:0]       level
);
   logic bad_index;
   logic bad_mode;
   logic bad_level;
   logic bad_cmd;

   always_comb begin
      bad_index = command_param_index != margin_pkg::IDX_LAST_MARGIN; // R6
      bad_mode  = !cmd_allowed; // R7
      bad_cmd   = (param_cmd[15:8] != margin_pkg::CMD_FIELD_MARGIN)
                  || ((param_cmd[1:0] != margin_pkg::SEL_PFLASH)
                  && (param_cmd[1:0] != margin_pkg::SEL_EEPROM)); // R9
      // only the five documented codes are accepted
      bad_level = param_level > margin_pkg::LVL_FIELD0; // R8
      fault         = bad_index || bad_mode || bad_cmd || bad_level;
      target_pflash = param_cmd[1:0] == margin_pkg::SEL_PFLASH;
      // codes 0..4 map one to one onto the read level driven out
      level         = param_level[2:0]; // R4 R5
   end
endmodule

//--- field_margin_level_command.sv
// field margin level command sequencer with avalon-mm register slave
// Contract
// (R1) eeprom target changes eeprom read level only
// (R2) pflash target changes pflash and eeprom levels
// (R3) no pflash-only margin setting exists
// (R4) codes 0,1,2: normal, user erased, user programmed
// (R5) codes 3,4: field erased, field programmed
// (R6) index not 001 at launch: access error
// (R7) command unavailable in mode: access error
// (R8) invalid level code: access error
// (R9) software loads 0x0E and block code first
// (R10) launch by clearing complete flag, then set
// (R11) level holds until next command or reset
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module field_margin_level_command (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic [2:0]       pflash_read_level,
   output logic [2:0]       eeprom_read_level,
   output logic             irq
);
   typedef enum {ST_IDLE, ST_CHECK, ST_APPLY, ST_FINISH} seq_state_e;

   seq_state_e  state;
   logic        ack;
   logic        do_write;
   logic [31:0] wmask;
   logic [31:0] wbits;
   logic [31:0] next_rdata;
   logic        command_complete_flag;
   logic        access_error_flag;
   logic        protection_violation_flag;
   logic [1:0]  verify_status;
   logic [2:0]  command_param_index;
   logic [15:0] command_param_array [margin_pkg::PARAM_WORDS];
   logic        mode_restricted;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;
   logic        launch;
   logic        set_err;
   logic        set_done;
   logic        fault;
   logic        target_pflash;
   logic [2:0]  level;

   assign protection_violation_flag = 1'b0;
   assign verify_status             = 2'h0;

   // one wait state: request seen, answered on the next edge
   assign avs_waitrequest = (avs_read || avs_write) && !ack;
   assign do_write        = avs_write && ack;
   assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                   {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wbits = avs_writedata & wmask;

   // writing one to the complete flag while idle launches
   assign launch = do_write && (avs_address == margin_pkg::OFF_STATUS)
                   && wbits[margin_pkg::BIT_COMMAND_COMPLETE_FLAG] && command_complete_flag; // R10

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read || avs_write) && !ack;
      end
   end

   margin_check u_check (
      .param_cmd           (command_param_array[0]),
      .param_level         (command_param_array[1]),
      .command_param_index (command_param_index),
      .cmd_allowed         (!mode_restricted),
      .fault               (fault),
      .target_pflash       (target_pflash),
      .level               (level)
   );

   // sequencer
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         case (state)
            ST_IDLE: begin
               if (launch) begin
                  state <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               // a failed check skips execution entirely
               if (fault) begin
                  state <= ST_FINISH; // R6 R7 R8
               end else begin
                  state <= ST_APPLY;
               end
            end
            ST_APPLY: begin
               state <= ST_FINISH;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   assign set_err  = (state == ST_CHECK) && fault; // R6 R7 R8
   assign set_done = state == ST_FINISH;

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         command_complete_flag <= margin_pkg::RST_COMMAND_COMPLETE_FLAG;
      end else if (launch) begin
         command_complete_flag <= 1'b0; // R10
      end else if (set_done) begin
         command_complete_flag <= 1'b1; // R10
      end
   end

   // sticky error, set wins over a simultaneous write-one clear
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         access_error_flag <= 1'b0;
      end else if (set_err) begin
         access_error_flag <= 1'b1; // R6 R7 R8
      end else if (do_write && (avs_address == margin_pkg::OFF_STATUS)
                   && wbits[margin_pkg::BIT_ACCESS_ERROR_FLAG]) begin
         access_error_flag <= 1'b0;
      end
   end

   // read levels: held until the next good command or reset
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pflash_read_level <= margin_pkg::RST_LEVEL; // R11
         eeprom_read_level <= margin_pkg::RST_LEVEL; // R11
      end else if (state == ST_APPLY) begin
         // eeprom follows either target, so pflash alone never moves
         eeprom_read_level <= level; // R1 R2 R3
         if (target_pflash) begin
            pflash_read_level <= level; // R2
         end
      end
   end

   // parameter array and index, frozen while a command runs
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         command_param_index <= margin_pkg::RST_INDEX;
         for (int i = 0; i < margin_pkg::PARAM_WORDS; i++) begin
            command_param_array[i] <= 16'h0000;
         end
      end else if (do_write && command_complete_flag) begin
         if (avs_address == margin_pkg::OFF_INDEX && avs_byteenable[0]) begin
            command_param_index <= avs_writedata[2:0];
         end else if (avs_address == margin_pkg::OFF_PARAM
                      && command_param_index < 3'(margin_pkg::PARAM_WORDS)) begin
            command_param_array[command_param_index] <=
               (command_param_array[command_param_index] & ~wmask[15:0])
               | wbits[15:0]; // R9
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         mode_restricted <= 1'b0;
      end else if (do_write && avs_address == margin_pkg::OFF_MODE
                   && avs_byteenable[0]) begin
         mode_restricted <= avs_writedata[0];
      end
   end

   // interrupt status, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_status <= 2'h0;
      end else begin
         for (int b = 0; b < 2; b++) begin
            if ((b == margin_pkg::IRQ_DONE && set_done)
                || (b == margin_pkg::IRQ_ERR && set_err)) begin
               irq_status[b] <= 1'b1;
            end else if (do_write && avs_address == margin_pkg::OFF_IRQ_STAT
                         && wbits[b]) begin
               irq_status[b] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         irq_mask <= margin_pkg::RST_MASK;
      end else if (do_write && avs_address == margin_pkg::OFF_IRQ_MASK
                   && avs_byteenable[0]) begin
         irq_mask <= avs_writedata[1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // read data captured in the wait cycle, stands at the answer edge
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (avs_address == margin_pkg::OFF_STATUS) begin
         next_rdata[margin_pkg::BIT_COMMAND_COMPLETE_FLAG]   = command_complete_flag;
         next_rdata[margin_pkg::BIT_ACCESS_ERROR_FLAG] = access_error_flag;
         next_rdata[margin_pkg::BIT_PROTECTION_VIOLATION_FLAG] = protection_violation_flag;
         next_rdata[1:0]                    = verify_status;
      end else if (avs_address == margin_pkg::OFF_INDEX) begin
         next_rdata[2:0] = command_param_index;
      end else if (avs_address == margin_pkg::OFF_PARAM) begin
         if (command_param_index < 3'(margin_pkg::PARAM_WORDS)) begin
            next_rdata[15:0] = command_param_array[command_param_index];
         end
      end else if (avs_address == margin_pkg::OFF_MODE) begin
         next_rdata[0] = mode_restricted;
      end else if (avs_address == margin_pkg::OFF_LEVELS) begin
         next_rdata[margin_pkg::LVL_PFLASH_LSB +: 3] = pflash_read_level;
         next_rdata[margin_pkg::LVL_EEPROM_LSB +: 3] = eeprom_read_level;
         next_rdata[margin_pkg::LVL_BUSY]            = !command_complete_flag;
      end else if (avs_address == margin_pkg::OFF_IRQ_STAT) begin
         next_rdata[1:0] = irq_status;
      end else if (avs_address == margin_pkg::OFF_IRQ_MASK) begin
         next_rdata[1:0] = irq_mask;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack) begin
         avs_readdata <= next_rdata;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);

   sequence launch_seq;
      launch;
   endsequence

   sequence checked_seq;
      state == ST_CHECK;
   endsequence

   // later steps of a command
   sequence applied_seq;
      state == ST_APPLY;
   endsequence

   sequence finished_seq;
      state == ST_FINISH;
   endsequence

   launch_clears_a: assert property (launch_seq |=> !command_complete_flag ##1 // R10
      (state == ST_APPLY || state == ST_FINISH))
      else $error("complete flag not cleared by launch");

   command_complete_flag_returns_a: assert property ($fell(command_complete_flag) |-> // R10
      ##[2:3] command_complete_flag)
      else $error("complete flag not set again in time");

   bad_index_a: assert property (checked_seq and ##0 // R6
      (command_param_index != 3'h1) |=> access_error_flag && state == ST_FINISH)
      else $error("bad index did not raise access error");

   mode_refused_a: assert property (checked_seq and ##0 mode_restricted // R7
      |=> access_error_flag && $stable(pflash_read_level)
      && $stable(eeprom_read_level))
      else $error("restricted mode command was executed");

   bad_level_a: assert property (checked_seq and ##0 // R8
      (command_param_array[1] > 16'h0004) |=> access_error_flag ##1
      $stable(eeprom_read_level))
      else $error("invalid level accepted");

   eeprom_only_a: assert property (state == ST_APPLY && !target_pflash // R1
      |=> $stable(pflash_read_level) && eeprom_read_level == $past(level))
      else $error("eeprom target touched pflash level");

   pflash_both_a: assert property (state == ST_APPLY && target_pflash // R2
      |=> pflash_read_level == eeprom_read_level
      && pflash_read_level == command_param_array[1][2:0])
      else $error("pflash target did not set both levels");

   no_pflash_alone_a: assert property ($changed(pflash_read_level) // R3
      |-> eeprom_read_level == pflash_read_level)
      else $error("pflash margin applied alone");

   level_hold_a: assert property ($past(state) != ST_APPLY && $past(rst_b) // R11
      |-> $stable(pflash_read_level) && $stable(eeprom_read_level))
      else $error("read level changed without a command");

   irq_level_a: assert property (set_err && irq_mask[margin_pkg::IRQ_ERR] |=> irq)
      else $error("unmasked access error raised no interrupt");

   good_path_a: assert property (checked_seq and ##0 !fault // R10
      |=> applied_seq ##1 finished_seq ##1 command_complete_flag)
      else $error("good command did not run to completion");

   err_path_a: assert property (checked_seq and ##0 fault // R6 R7 R8
      |=> finished_seq ##1 (command_complete_flag && access_error_flag))
      else $error("refused command did not end with access error");

   level_code_a: assert property (applied_seq // R4 R5
      |=> eeprom_read_level == command_param_array[1][2:0]
      && eeprom_read_level <= 3'h4)
      else $error("level code not driven as given");

   command_complete_flag_hold_a: assert property (command_complete_flag && !launch // R10
      |=> command_complete_flag)
      else $error("complete flag dropped without launch");

   idle_when_done_a: assert property (command_complete_flag |-> state == ST_IDLE) // R10
      else $error("sequencer busy while complete flag set");

   index_frozen_a: assert property (!command_complete_flag
      |=> $stable(command_param_index))
      else $error("parameter index changed while command runs");

   done_irq_a: assert property ($rose(command_complete_flag) // R10
      |-> irq_status[margin_pkg::IRQ_DONE])
      else $error("done event not recorded");

   error_sticky_a: assert property (access_error_flag
      && !(do_write && avs_address == margin_pkg::OFF_STATUS
      && wbits[margin_pkg::BIT_ACCESS_ERROR_FLAG]) |=> access_error_flag)
      else $error("access error cleared without a write");

   bus_answer_a: assert property ($rose(avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus answer not given after one wait state");
endmodule

//--- tb.sv
// self-checking bench for the field margin level command block
`timescale 1ns/1ps
module tb;
   logic        clk_sys;
   logic        rst_b;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [2:0]  pflash_read_level;
   logic [2:0]  eeprom_read_level;
   logic        irq;
   int          err_total;
   int          n_tests;
   logic [2:0]  pf;
   logic [2:0]  ee;
   logic [1:0]  mask_v;
   logic [31:0] q;

   field_margin_level_command dut (
      .clk_sys           (clk_sys),
      .rst_b             (rst_b),
      .avs_address       (avs_address),
      .avs_read          (avs_read),
      .avs_write         (avs_write),
      .avs_writedata     (avs_writedata),
      .avs_byteenable    (avs_byteenable),
      .avs_readdata      (avs_readdata),
      .avs_waitrequest   (avs_waitrequest),
      .pflash_read_level (pflash_read_level),
      .eeprom_read_level (eeprom_read_level),
      .irq               (irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task summarize();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one bus access: request held until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
      r = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task rd(input logic [4:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask

   // load parameters, launch, wait for completion and check the outcome
   task cmd(input logic [1:0] sel, input logic [15:0] lvl, input logic [2:0] idx,
            input logic bad);
      logic [31:0] r;
      int n;
      n = 0;
      wr(margin_pkg::OFF_INDEX, 32'h0);
      wr(margin_pkg::OFF_PARAM, {16'h0, margin_pkg::CMD_FIELD_MARGIN, 6'h0, sel});
      wr(margin_pkg::OFF_INDEX, 32'h1);
      wr(margin_pkg::OFF_PARAM, {16'h0, lvl});
      wr(margin_pkg::OFF_INDEX, {29'h0, idx});
      wr(margin_pkg::OFF_STATUS, 32'h80);
      rd(margin_pkg::OFF_STATUS, r);
      chk("complete flag after launch", 32'h0, {31'h0, r[7]});
      while (r[7] !== 1'b1 && n < 20) begin
         rd(margin_pkg::OFF_STATUS, r);
         n++;
      end
      chk("status", bad ? 32'hA0 : 32'h80, r & 32'hFF);
      if (!bad) begin
         ee = lvl[2:0];
         if (sel == margin_pkg::SEL_PFLASH) pf = lvl[2:0];
      end
      chk("pflash level", {29'h0, pf}, {29'h0, pflash_read_level});
      chk("eeprom level", {29'h0, ee}, {29'h0, eeprom_read_level});
      rd(margin_pkg::OFF_LEVELS, r);
      chk("levels reg", {25'h0, ee, 1'b0, pf}, r);
      chk("irq", {31'h0, (bad & mask_v[1]) | mask_v[0]}, {31'h0, irq});
      rd(margin_pkg::OFF_IRQ_STAT, r);
      chk("error event", {31'h0, bad}, {31'h0, r[1]});
      chk("done event", 32'h1, {31'h0, r[0]});
      wr(margin_pkg::OFF_IRQ_STAT, 32'h3);
      wr(margin_pkg::OFF_STATUS, 32'h20);
      rd(margin_pkg::OFF_STATUS, r);
      chk("status cleared", 32'h80, r & 32'hFF);
      chk("irq cleared", 32'h0, {31'h0, irq});
   endtask

   initial begin
      #(8 * 20000);
      err_total++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end

   initial begin
      err_total = 0;
      n_tests = 0;
      pf = 3'h0;
      ee = 3'h0;
      mask_v = 2'h0;
      rst_b = 1'b0;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(margin_pkg::OFF_STATUS, q);
      chk("status reset", 32'h80, q);
      rd(margin_pkg::OFF_LEVELS, q);
      chk("levels reset", 32'h0, q);
      chk("irq reset", 32'h0, {31'h0, irq});
      rd(5'h1C, q);
      chk("unmapped read", 32'h0, q);
      for (int l = 0; l < 5; l++) begin
         cmd(margin_pkg::SEL_PFLASH, 16'(l), 3'h1, 1'b0);
      end
      cmd(margin_pkg::SEL_EEPROM, margin_pkg::LVL_USER0, 3'h1, 1'b0);
      cmd(margin_pkg::SEL_EEPROM, margin_pkg::LVL_FIELD1, 3'h1, 1'b0);
      cmd(2'h2, margin_pkg::LVL_USER1, 3'h1, 1'b1);
      cmd(2'h3, margin_pkg::LVL_USER1, 3'h1, 1'b1);
      mask_v = 2'h2;
      wr(margin_pkg::OFF_IRQ_MASK, {30'h0, mask_v});
      cmd(margin_pkg::SEL_PFLASH, margin_pkg::LVL_USER1, 3'h2, 1'b1);
      cmd(margin_pkg::SEL_PFLASH, margin_pkg::LVL_USER1, 3'h0, 1'b1);
      wr(margin_pkg::OFF_MODE, 32'h1);
      cmd(margin_pkg::SEL_PFLASH, margin_pkg::LVL_USER1, 3'h1, 1'b1);
      wr(margin_pkg::OFF_MODE, 32'h0);
      cmd(margin_pkg::SEL_PFLASH, 16'h0005, 3'h1, 1'b1);
      cmd(margin_pkg::SEL_EEPROM, 16'h0100, 3'h1, 1'b1);
      mask_v = 2'h1;
      wr(margin_pkg::OFF_IRQ_MASK, {30'h0, mask_v});
      cmd(margin_pkg::SEL_PFLASH, 16'h0007, 3'h1, 1'b1);
      cmd(margin_pkg::SEL_PFLASH, margin_pkg::LVL_USER1, 3'h1, 1'b0);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      pf = 3'h0;
      ee = 3'h0;
      mask_v = 2'h0;
      @(posedge clk_sys);
      chk("pflash after reset", 32'h0, {29'h0, pflash_read_level});
      chk("eeprom after reset", 32'h0, {29'h0, eeprom_read_level});
      cmd(margin_pkg::SEL_EEPROM, margin_pkg::LVL_FIELD0, 3'h1, 1'b0);
      summarize();
   end
endmodule
